// ===== src/acr_pkg.sv
// package with register map, fields and types of the converter control block
package acr_pkg;
	localparam logic [2:0] OFS_SC1 = 3'h0;
	localparam logic [2:0] OFS_SC2 = 3'h1;
	localparam logic [2:0] OFS_RH = 3'h2;
	localparam logic [2:0] OFS_RL = 3'h3;
	localparam logic [2:0] OFS_CVH = 3'h4;
	localparam logic [2:0] OFS_CVL = 3'h5;
	localparam logic [2:0] OFS_CFG = 3'h6;
	localparam int DONE_BIT = 7;
	localparam int IE_BIT = 6;
	localparam int CONT_BIT = 5;
	localparam int ACT_BIT = 7;
	localparam int TRG_BIT = 6;
	localparam int CMPEN_BIT = 5;
	localparam int CMPGE_BIT = 4;
	localparam int MODE_LSB = 2;
	localparam logic [4:0] CH_LAST_INPUT = 5'h1b;
	localparam logic [4:0] CH_RESERVED = 5'h1c;
	localparam logic [4:0] CH_REFH = 5'h1d;
	localparam logic [4:0] CH_REFL = 5'h1e;
	localparam logic [4:0] CH_OFF = 5'h1f;
	localparam logic [1:0] MODE_8 = 2'h0;
	localparam logic [1:0] MODE_10 = 2'h2;
	localparam logic [4:0] CH_RESET = 5'h1f;
	localparam logic [7:0] CFG_RESET = 8'h00;
	localparam logic [9:0] CV_RESET = 10'h000;

	typedef struct packed {
		logic wr;
		logic rd;
		logic [2:0] addr;
		logic [7:0] wdata;
	} acr_bus_t;

	typedef enum logic [0:0] {
		ST_IDLE = 1'b0,
		ST_CONV = 1'b1
	} acr_state_t;

	typedef enum logic [2:0] {
		SRC_INPUT = 3'b000,
		SRC_REFH = 3'b001,
		SRC_REFL = 3'b010,
		SRC_NONE = 3'b011,
		SRC_OFF = 3'b100
	} acr_src_t;

	// classify a channel code
	function automatic acr_src_t chan_kind(input logic [4:0] ch);
		acr_src_t k;
		k = SRC_NONE;
		if (ch <= CH_LAST_INPUT) k = SRC_INPUT;
		else if (ch == CH_REFH) k = SRC_REFH;
		else if (ch == CH_REFL) k = SRC_REFL;
		else if (ch == CH_OFF) k = SRC_OFF;
		return k;
	endfunction
endpackage

// ===== src/acr_trig_edge.sv
// rising-edge detector for the hardware trigger input
module acr_trig_edge (
	// clock and reset
	input wire logic clk_sys,
	input wire logic rst_n,
	// trigger
	input wire logic trig_in,
	output logic trig_evt
);
	logic prev_reg;
	logic prev_next;

	// next value of the previous-level store
	always_comb begin
		prev_next = trig_in;
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) prev_reg <= 1'b1;
		else prev_reg <= prev_next;
	end

	// one event per assertion, a held level is not retaken
	assign trig_evt = trig_in && !prev_reg;
endmodule // acr_trig_edge

// ===== src/acr_compare.sv
// automatic compare of a result against the programmed value
module acr_compare (
	// operands
	input wire logic [9:0] result,
	input wire logic [9:0] cmp_val,
	// setup
	input wire logic mode10,
	input wire logic ge_sel,
	output logic hit
);
	logic [9:0] a;
	logic [9:0] b;

	// high bits only take part in 10-bit mode
	always_comb begin
		a = mode10 ? result : {2'h0, result[7:0]};
		b = mode10 ? cmp_val : {2'h0, cmp_val[7:0]};
		hit = ge_sel ? (a >= b) : (a < b);
	end
endmodule // acr_compare

// ===== src/acr_ctrl.sv
// converter control: status/control registers, sequencing, results
module acr_ctrl (
	// clock and reset
	input wire logic clk_sys,
	input wire logic rst_n,
	// register port
	input acr_pkg::acr_bus_t bus_req,
	output logic [7:0] rd_data,
	// periodic trigger from counter
	input wire logic hardware_trigger_in,
	// analog front end
	output logic afe_start,
	output logic afe_abort,
	output logic afe_power,
	output logic [4:0] afe_channel,
	output acr_pkg::acr_src_t afe_src,
	input wire logic afe_done,
	input wire logic [9:0] afe_result,
	// interrupt line
	output logic conv_irq
);
	acr_pkg::acr_state_t state_reg;
	acr_pkg::acr_state_t state_next;
	logic done_reg;
	logic done_next;
	logic ie_reg;
	logic ie_next;
	logic cont_reg;
	logic cont_next;
	logic [4:0] chan_reg;
	logic [4:0] chan_next;
	logic trg_reg;
	logic trg_next;
	logic cmpen_reg;
	logic cmpen_next;
	logic cmpge_reg;
	logic cmpge_next;
	logic [9:0] cv_reg;
	logic [9:0] cv_next;
	logic [7:0] cfg_reg;
	logic [7:0] cfg_next;
	logic [9:0] result_reg;
	logic [9:0] result_next;
	logic lock_reg;
	logic lock_next;
	logic start_reg;
	logic start_next;
	logic abort_reg;
	logic abort_next;
	logic [7:0] rdata_reg;
	logic [7:0] rdata_next;

	logic wr_sc1;
	logic wr_sc2;
	logic wr_cfg;
	logic rd_rh;
	logic rd_rl;
	logic mode10;
	logic hw_evt;
	logic cmp_hit;
	logic conv_end;
	logic store;
	logic go;
	logic mode_change;

	// register strobes decoded from the port
	assign wr_sc1 = bus_req.wr && (bus_req.addr == acr_pkg::OFS_SC1);
	assign wr_sc2 = bus_req.wr && (bus_req.addr == acr_pkg::OFS_SC2);
	assign wr_cfg = bus_req.wr && (bus_req.addr == acr_pkg::OFS_CFG);
	assign rd_rh = bus_req.rd && (bus_req.addr == acr_pkg::OFS_RH);
	assign rd_rl = bus_req.rd && (bus_req.addr == acr_pkg::OFS_RL);
	// reserved codes behave as 8-bit
	assign mode10 = cfg_reg[acr_pkg::MODE_LSB +: 2] == acr_pkg::MODE_10;
	assign mode_change = wr_cfg
		&& (bus_req.wdata[acr_pkg::MODE_LSB +: 2] != cfg_reg[acr_pkg::MODE_LSB +: 2]);

	// hardware trigger edge
	acr_trig_edge u_trig (
		.clk_sys(clk_sys),
		.rst_n(rst_n),
		.trig_in(hardware_trigger_in),
		.trig_evt(hw_evt)
	);

	// compare of the fresh result
	acr_compare u_cmp (
		.result(afe_result),
		.cmp_val(cv_reg),
		.mode10(mode10),
		.ge_sel(cmpge_reg),
		.hit(cmp_hit)
	);

	// end of conversion and whether its result is kept
	// a done pulse while idle is ignored, the converter is not running
	assign conv_end = (state_reg == acr_pkg::ST_CONV) && afe_done;
	assign store = conv_end && (!cmpen_reg || cmp_hit);

	// conversion sequencing
	always_comb begin
		go = 1'b0;
		state_next = state_reg;
		if (wr_sc1) begin
			// software start only with a live channel and software trigger
			if (bus_req.wdata[4:0] != acr_pkg::CH_OFF && !trg_reg) go = 1'b1;
		end else if (conv_end && cont_reg && chan_reg != acr_pkg::CH_OFF) begin
			go = 1'b1;
		// a trigger edge during a conversion is dropped, not queued
		end else if (state_reg == acr_pkg::ST_IDLE && trg_reg && hw_evt
			&& chan_reg != acr_pkg::CH_OFF) begin
			go = 1'b1;
		end
		case (state_reg)
			acr_pkg::ST_IDLE: begin
				if (go) state_next = acr_pkg::ST_CONV;
			end
			acr_pkg::ST_CONV: begin
				// a write aborts; single mode drops back to idle
				if (go) state_next = acr_pkg::ST_CONV;
				else if (wr_sc1 || conv_end) state_next = acr_pkg::ST_IDLE;
			end
			default: state_next = acr_pkg::ST_IDLE;
		endcase
		start_next = go;
		abort_next = wr_sc1 && (state_reg == acr_pkg::ST_CONV) && !conv_end;
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			state_reg <= acr_pkg::ST_IDLE;
			start_reg <= 1'b0;
			abort_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			start_reg <= start_next;
			abort_reg <= abort_next;
		end
	end

	// control fields written by software
	always_comb begin
		ie_next = ie_reg;
		cont_next = cont_reg;
		chan_next = chan_reg;
		trg_next = trg_reg;
		cmpen_next = cmpen_reg;
		cmpge_next = cmpge_reg;
		cv_next = cv_reg;
		cfg_next = cfg_reg;
		if (wr_sc1) begin
			ie_next = bus_req.wdata[acr_pkg::IE_BIT];
			cont_next = bus_req.wdata[acr_pkg::CONT_BIT];
			chan_next = bus_req.wdata[4:0];
		end
		// reserved low bits are not stored and read back as zero
		if (wr_sc2) begin
			trg_next = bus_req.wdata[acr_pkg::TRG_BIT];
			cmpen_next = bus_req.wdata[acr_pkg::CMPEN_BIT];
			cmpge_next = bus_req.wdata[acr_pkg::CMPGE_BIT];
		end
		if (bus_req.wr && bus_req.addr == acr_pkg::OFS_CVH) cv_next[9:8] = bus_req.wdata[1:0];
		if (bus_req.wr && bus_req.addr == acr_pkg::OFS_CVL) cv_next[7:0] = bus_req.wdata;
		if (wr_cfg) cfg_next = bus_req.wdata;
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			ie_reg <= 1'b0;
			cont_reg <= 1'b0;
			chan_reg <= acr_pkg::CH_RESET;
			trg_reg <= 1'b0;
			cmpen_reg <= 1'b0;
			cmpge_reg <= 1'b0;
			cv_reg <= acr_pkg::CV_RESET;
			cfg_reg <= acr_pkg::CFG_RESET;
		end else begin
			ie_reg <= ie_next;
			cont_reg <= cont_next;
			chan_reg <= chan_next;
			trg_reg <= trg_next;
			cmpen_reg <= cmpen_next;
			cmpge_reg <= cmpge_next;
			cv_reg <= cv_next;
			cfg_reg <= cfg_next;
		end
	end

	// done flag, result store and read lock
	always_comb begin
		done_next = done_reg;
		result_next = result_reg;
		lock_next = lock_reg;
		if (wr_sc1 || rd_rl) done_next = 1'b0;
		// a kept result in the same cycle as a clear leaves the flag set
		if (store) done_next = 1'b1;
		if (rd_rl) lock_next = 1'b0;
		if (rd_rh && mode10) lock_next = 1'b1;
		if (!mode10) lock_next = 1'b0;
		// old result bits no longer match the new width
		if (mode_change) begin
			result_next = 10'h000;
			lock_next = 1'b0;
		end else if (store && !lock_reg) begin
			result_next = mode10 ? afe_result : {2'h0, afe_result[7:0]};
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			done_reg <= 1'b0;
			result_reg <= 10'h000;
			lock_reg <= 1'b0;
		end else begin
			done_reg <= done_next;
			result_reg <= result_next;
			lock_reg <= lock_next;
		end
	end

	// read data, present only in the cycle after the strobe
	always_comb begin
		rdata_next = 8'h00;
		if (bus_req.rd) begin
			case (bus_req.addr)
				acr_pkg::OFS_SC1: rdata_next = {done_reg, ie_reg, cont_reg, chan_reg};
				acr_pkg::OFS_SC2: rdata_next = {state_reg == acr_pkg::ST_CONV, trg_reg,
					cmpen_reg, cmpge_reg, 4'h0};
				acr_pkg::OFS_RH: rdata_next = {6'h00, mode10 ? result_reg[9:8] : 2'h0};
				acr_pkg::OFS_RL: rdata_next = result_reg[7:0];
				acr_pkg::OFS_CVH: rdata_next = {6'h00, cv_reg[9:8]};
				acr_pkg::OFS_CVL: rdata_next = cv_reg[7:0];
				acr_pkg::OFS_CFG: rdata_next = cfg_reg;
				default: rdata_next = 8'h00;
			endcase
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) rdata_reg <= 8'h00;
		else rdata_reg <= rdata_next;
	end

	// outputs
	assign rd_data = rdata_reg;
	assign afe_start = start_reg;
	assign afe_abort = abort_reg;
	// converter powered only while converting
	assign afe_power = state_reg == acr_pkg::ST_CONV;
	assign afe_channel = chan_reg;
	// the reserved code still converts, it only decodes to none
	assign afe_src = acr_pkg::chan_kind(chan_reg);
	assign conv_irq = done_reg && ie_reg;

	// checks
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_n);

	sequence s_sw_start;
		wr_sc1 && !trg_reg && bus_req.wdata[4:0] != acr_pkg::CH_OFF;
	endsequence
	sequence s_running;
		afe_start && state_reg == acr_pkg::ST_CONV;
	endsequence
	sequence s_single_end;
		conv_end && !cont_reg && !wr_sc1;
	endsequence
	sequence s_cmp_miss;
		conv_end && cmpen_reg && !cmp_hit && !wr_sc1 && !rd_rl && !wr_cfg;
	endsequence
	sequence s_hw_start;
		state_reg == acr_pkg::ST_IDLE && trg_reg && hw_evt && !wr_sc1
			&& chan_reg != acr_pkg::CH_OFF;
	endsequence

	AST_SW_WRITE_STARTS: assert property (s_sw_start |=> s_running)
		else $error("control-one write did not start a conversion");
	AST_OFF_NO_START: assert property (
		wr_sc1 && bus_req.wdata[4:0] == acr_pkg::CH_OFF |=> !afe_start && !afe_power)
		else $error("off channel started a conversion");
	AST_DONE_SET: assert property (store |=> done_reg)
		else $error("done flag not set at kept conversion");
	AST_CMP_MISS: assert property (
		s_cmp_miss |=> done_reg == $past(done_reg) && $stable(result_reg))
		else $error("compare miss changed flag or result");
	AST_DONE_CLEAR: assert property ((wr_sc1 || rd_rl) && !store |=> !done_reg)
		else $error("done flag not cleared");
	AST_IRQ: assert property ($rose(done_reg) && ie_reg |-> conv_irq)
		else $error("interrupt missing on done");
	AST_SINGLE_IDLE: assert property (s_single_end |=> !afe_power && !afe_start)
		else $error("single conversion did not power down");
	AST_CONT_AGAIN: assert property (
		conv_end && cont_reg && !wr_sc1 && chan_reg != acr_pkg::CH_OFF |=> s_running)
		else $error("continuous mode did not restart");
	AST_ACTIVE_READ: assert property (
		bus_req.rd && bus_req.addr == acr_pkg::OFS_SC2
		|=> rd_data[acr_pkg::ACT_BIT] == $past(afe_power))
		else $error("active flag read wrong");
	AST_LOCK_HOLD: assert property (lock_reg && !rd_rl && !wr_cfg |=> $stable(result_reg))
		else $error("locked result changed");
	AST_RH_8BIT: assert property (rd_rh && !mode10 |=> rd_data == 8'h00)
		else $error("high result nonzero in 8-bit mode");
	AST_HW_ONCE: assert property (
		state_reg == acr_pkg::ST_IDLE && !cont_reg && trg_reg && !bus_req.wr
		&& hardware_trigger_in && !hw_evt |=> !afe_start)
		else $error("held trigger started another conversion");

	// abort pulse and active flag follow the sequencer
	AST_ABORT_PULSE: assert property (
		wr_sc1 && state_reg == acr_pkg::ST_CONV && !conv_end |=> afe_abort)
		else $error("write during conversion gave no abort");
	AST_START_ACTIVE: assert property (afe_start |-> afe_power)
		else $error("active flag not set at start");
	AST_ABORT_IDLE: assert property (afe_abort && !afe_start |-> !afe_power)
		else $error("active flag kept after abort");

	// start source as selected
	AST_HW_STARTS: assert property (s_hw_start |=> s_running)
		else $error("trigger edge did not start a conversion");
	AST_HW_NO_SW: assert property (wr_sc1 && trg_reg |=> !afe_start)
		else $error("write started a conversion in hardware mode");

	// done flag only moves at its own events
	AST_DONE_HOLD: assert property (done_reg && !wr_sc1 && !rd_rl |=> done_reg)
		else $error("done flag lost without a clear");
	AST_IDLE_DONE_IGNORED: assert property (
		state_reg == acr_pkg::ST_IDLE && afe_done && !wr_sc1 && !rd_rl
		|=> done_reg == $past(done_reg))
		else $error("done pulse while idle changed the flag");

	// result path, lock and width
	AST_RESULT_STORE: assert property (
		store && !lock_reg && !wr_cfg |=> result_reg[7:0] == $past(afe_result[7:0]))
		else $error("kept result not stored");
	AST_STORE_8BIT: assert property (
		store && !lock_reg && !mode10 && !wr_cfg |=> result_reg[9:8] == 2'h0)
		else $error("8-bit result has upper bits set");
	AST_RH_UPPER_ZERO: assert property (
		bus_req.rd && bus_req.addr == acr_pkg::OFS_RH |=> rd_data[7:2] == 6'h00)
		else $error("high result unused bits nonzero");
	AST_LOCK_SET: assert property (rd_rh && mode10 && !bus_req.wr |=> lock_reg)
		else $error("high read did not lock results");
	AST_NO_LOCK_8: assert property (!mode10 |-> !lock_reg)
		else $error("lock held in 8-bit mode");
	AST_MODE_CLEAR: assert property (mode_change |=> result_reg == 10'h000 && !lock_reg)
		else $error("mode change kept old result");

	// an off channel never runs the converter
	AST_OFF_IDLE: assert property (chan_reg == acr_pkg::CH_OFF |-> !afe_power)
		else $error("converter powered with channel off");
endmodule // acr_ctrl

// ===== dv/acr_ctrl_tb.sv
// self-checking bench for the converter control block
`define CK(nm, ex, gt) begin tests_run++; if ((gt) !== (ex)) begin err_total++; \
	$display("[ERR] %s exp %h got %h", nm, ex, gt); end end
module acr_ctrl_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk_sys;
	logic rst_n;
	acr_pkg::acr_bus_t bus_req;
	logic [7:0] rd_data;
	logic hardware_trigger_in;
	logic afe_start, afe_abort, afe_power, afe_done, conv_irq;
	logic [4:0] afe_channel;
	acr_pkg::acr_src_t afe_src;
	logic [9:0] afe_result;
	int err_total;
	int tests_run;
	logic [7:0] rv;
	logic seen;

	acr_ctrl u_dut (.clk_sys(clk_sys), .rst_n(rst_n), .bus_req(bus_req), .rd_data(rd_data),
		.hardware_trigger_in(hardware_trigger_in), .afe_start(afe_start),
		.afe_abort(afe_abort), .afe_power(afe_power), .afe_channel(afe_channel),
		.afe_src(afe_src), .afe_done(afe_done), .afe_result(afe_result), .conv_irq(conv_irq));

	// 100 MHz clock
	initial begin
		clk_sys = 1'b0;
		forever #5 clk_sys = ~clk_sys;
	end

	// verdict and end of run
	task automatic complete_run();
		$display("checks %0d mismatches %0d", tests_run, err_total);
		if (err_total == 0 && tests_run > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	// one-cycle register write; tasks end just after an edge
	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		@(posedge clk_sys);
		bus_req.wr <= 1'b1;
		bus_req.addr <= a;
		bus_req.wdata <= d;
		@(posedge clk_sys);
		bus_req.wr <= 1'b0;
		#1;
	endtask

	// one-cycle register read, data taken in the following cycle
	task automatic rd(input logic [2:0] a);
		@(posedge clk_sys);
		bus_req.rd <= 1'b1;
		bus_req.addr <= a;
		@(posedge clk_sys);
		bus_req.rd <= 1'b0;
		#1;
		rv = rd_data;
	endtask

	// look for a start pulse now and over the next n cycles
	task automatic watch(input int n);
		seen = (afe_start === 1'b1);
		repeat (n) begin
			@(posedge clk_sys);
			#1;
			if (afe_start === 1'b1) seen = 1'b1;
		end
	endtask

	// converter side: finish the running conversion with result r
	task automatic conv(input logic [9:0] r);
		int i;
		for (i = 0; i < 50 && afe_power !== 1'b1; i++) begin
			@(posedge clk_sys);
			#1;
		end
		if (afe_power !== 1'b1) begin
			err_total++;
			$display("[ERR] afe_power exp 1 got %b", afe_power);
			complete_run();
		end
		@(posedge clk_sys);
		afe_done <= 1'b1;
		afe_result <= r;
		@(posedge clk_sys);
		afe_done <= 1'b0;
		afe_result <= ~r;
		#1;
	endtask

	// reset values and the unmapped index
	task automatic t_reset();
		rd(3'h0); `CK("ctl1", 8'h1f, rv)
		rd(3'h1); `CK("ctl2", 8'h00, rv)
		rd(3'h2); `CK("res_hi", 8'h00, rv)
		wr(3'h7, 8'hff);
		rd(3'h7); `CK("unmapped", 8'h00, rv)
		`CK("power", 1'b0, afe_power)
	endtask

	// software single conversion, flag, interrupt, clear
	task automatic t_single();
		wr(3'h6, 8'h08);
		wr(3'h0, 8'h45);
		`CK("start", 1'b1, afe_start)
		rd(3'h1); `CK("active", 8'h80, rv)
		conv(10'h2a5);
		`CK("power", 1'b0, afe_power)
		`CK("irq", 1'b1, conv_irq)
		rd(3'h0); `CK("done", 8'hc5, rv)
		watch(5); `CK("no_restart", 1'b0, seen)
		rd(3'h1); `CK("idle", 8'h00, rv)
		rd(3'h2); `CK("res_hi", 8'h02, rv)
		rd(3'h3); `CK("res_lo", 8'ha5, rv)
		`CK("irq_clr", 1'b0, conv_irq)
		wr(3'h0, 8'h05);
		conv(10'h001);
		`CK("irq_masked", 1'b0, conv_irq)
		rd(3'h0); `CK("done2", 8'h85, rv)
		wr(3'h0, 8'h05);
		rd(3'h0); `CK("wr_clr", 8'h05, rv)
	endtask

	// write during a conversion, then switch off
	task automatic t_abort();
		wr(3'h0, 8'h06);
		`CK("abort", 1'b1, afe_abort)
		`CK("restart", 1'b1, afe_start)
		`CK("chan", 5'h06, afe_channel)
		wr(3'h0, 8'h1f);
		`CK("off_power", 1'b0, afe_power)
		watch(4); `CK("off_start", 1'b0, seen)
		rd(3'h1); `CK("aborted", 8'h00, rv)
	endtask

	// channel decode over boundary codes
	task automatic t_chan();
		logic [4:0] c [5] = '{5'h00, 5'h1b, 5'h1c, 5'h1d, 5'h1e};
		acr_pkg::acr_src_t k [5] = '{acr_pkg::SRC_INPUT, acr_pkg::SRC_INPUT,
			acr_pkg::SRC_NONE, acr_pkg::SRC_REFH, acr_pkg::SRC_REFL};
		for (int i = 0; i < 5; i++) begin
			wr(3'h0, {3'h0, c[i]});
			`CK("src", k[i], afe_src)
			`CK("start", 1'b1, afe_start)
		end
		wr(3'h0, 8'h1f);
		`CK("src_off", acr_pkg::SRC_OFF, afe_src)
	endtask

	// software continuous conversions and stop
	task automatic t_cont();
		wr(3'h0, 8'h23);
		conv(10'h011);
		watch(3); `CK("cont1", 1'b1, seen)
		conv(10'h012);
		watch(3); `CK("cont2", 1'b1, seen)
		wr(3'h0, 8'h1f);
		watch(4); `CK("stop", 1'b0, seen)
	endtask

	// hardware trigger, single then continuous
	task automatic t_hw();
		wr(3'h1, 8'h40);
		wr(3'h0, 8'h07);
		watch(4); `CK("hw_no_sw", 1'b0, seen)
		@(posedge clk_sys);
		hardware_trigger_in <= 1'b1;
		#1;
		watch(4); `CK("hw_start", 1'b1, seen)
		conv(10'h0aa);
		watch(6); `CK("hw_once", 1'b0, seen)
		rd(3'h1); `CK("hw_ctl2", 8'h40, rv)
		@(posedge clk_sys);
		hardware_trigger_in <= 1'b0;
		wr(3'h0, 8'h27);
		@(posedge clk_sys);
		hardware_trigger_in <= 1'b1;
		#1;
		watch(4); `CK("hw_cont", 1'b1, seen)
		conv(10'h0ab);
		watch(3); `CK("hw_cont2", 1'b1, seen)
		wr(3'h0, 8'h1f);
		@(posedge clk_sys);
		hardware_trigger_in <= 1'b0;
		wr(3'h1, 8'h00);
	endtask

	// compare: less, greater-equal, 8-bit uses the low byte only
	task automatic t_cmp();
		wr(3'h4, 8'h01);
		rd(3'h4); `CK("cv_hi", 8'h01, rv)
		wr(3'h5, 8'h00);
		wr(3'h1, 8'h20);
		wr(3'h0, 8'h01);
		conv(10'h0ff);
		rd(3'h0); `CK("lt_hit", 8'h81, rv)
		rd(3'h2); `CK("lt_hi", 8'h00, rv)
		rd(3'h3); `CK("lt_lo", 8'hff, rv)
		wr(3'h0, 8'h01);
		conv(10'h100);
		rd(3'h0); `CK("lt_miss", 8'h01, rv)
		rd(3'h3); `CK("kept", 8'hff, rv)
		wr(3'h1, 8'h30);
		wr(3'h0, 8'h01);
		conv(10'h100);
		rd(3'h0); `CK("ge_hit", 8'h81, rv)
		wr(3'h6, 8'h00);
		wr(3'h5, 8'h10);
		wr(3'h0, 8'h01);
		conv(10'h020);
		rd(3'h0); `CK("cmp8", 8'h81, rv)
		rd(3'h3); `CK("cmp8_lo", 8'h20, rv)
		wr(3'h1, 8'h00);
	endtask

	// read lock in 10-bit mode, none in 8-bit mode
	task automatic t_lock();
		wr(3'h6, 8'h08);
		rd(3'h3); `CK("mode_inv", 8'h00, rv)
		wr(3'h0, 8'h01);
		conv(10'h155);
		rd(3'h2); `CK("hi10", 8'h01, rv)
		wr(3'h0, 8'h01);
		conv(10'h2aa);
		rd(3'h3); `CK("locked", 8'h55, rv)
		wr(3'h6, 8'h00);
		wr(3'h0, 8'h01);
		conv(10'h333);
		rd(3'h2); `CK("hi8", 8'h00, rv)
		wr(3'h0, 8'h01);
		conv(10'h044);
		rd(3'h3); `CK("nolock", 8'h44, rv)
		wr(3'h6, 8'h0c);
		wr(3'h0, 8'h01);
		conv(10'h3c5);
		rd(3'h2); `CK("rsv_hi", 8'h00, rv)
		rd(3'h3); `CK("rsv_lo", 8'hc5, rv)
	endtask

	// main sequence
	initial begin
		err_total = 0;
		tests_run = 0;
		rst_n = 1'b0;
		bus_req = '0;
		hardware_trigger_in = 1'b0;
		afe_done = 1'b0;
		afe_result = 10'h000;
		repeat (12) @(posedge clk_sys);
		rst_n <= 1'b1;
		t_reset();
		t_single();
		t_abort();
		t_chan();
		t_cont();
		t_hw();
		t_cmp();
		t_lock();
		complete_run();
	end
endmodule // acr_ctrl_tb
